/* hdl/radio_cfg.svh */
// constants for the radio mode controller and air framer
// assumes the core clock runs at 40 MHz
`ifndef RADIO_CFG_SVH
`define RADIO_CFG_SVH
`define CLK_PERIOD_NS 25
`define CE_MIN_NS 15000
`define CE_MIN_CYC ((`CE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TX_MAX_NS 4000000
`define CS_MIN_NS 128000
`define ACK_WAIT_NS 250000
`define RETRY_STEP_NS 250000
`define PIPE_EN_RST 6'h03
`define FREQ_BASE_MHZ 12'h0960
`define PRE_ONE 8'hAA
`define PRE_ZERO 8'h55
`define AW_3 2'h1
`define AW_4 2'h2
`define MASK_3 40'h00_00FF_FFFF
`define MASK_4 40'h00_FFFF_FFFF
`define MASK_5 40'hFF_FFFF_FFFF
`define TOP_BIT_3 6'h17
`define TOP_BIT_4 6'h1F
`define TOP_BIT_5 6'h27
`define NUM_PIPES 6
`define TMR_W 18
`endif

/* hdl/radio_pkg.sv */
// types shared by the mode controller and the air framer
// assumes radio_cfg.svh supplies the numeric constants
package radio_pkg;
	typedef enum logic [2:0] {
		M_OFF = 3'h0, M_STBY1 = 3'h1, M_TX = 3'h3, M_STBY2 = 3'h2,
		M_ACK_WAIT = 3'h6, M_RETRY = 3'h7, M_RX = 3'h5, M_ACK_TX = 3'h4
	} mode_e;
	typedef enum logic [2:0] {
		F_IDLE = 3'h0, F_PRE = 3'h1, F_ADDR = 3'h3, F_CTL_HI = 3'h2,
		F_CTL_LO = 3'h6, F_PAY = 3'h7, F_CRC = 3'h5
	} frame_e;
	typedef struct packed {
		logic [5:0] len;
		logic [1:0] tag;
		logic       no_ack;
	} ctrl_s;
	typedef struct packed {
		logic [39:0] addr;
		logic [1:0]  aw;
		ctrl_s       ctrl;
	} tx_desc_s;
	typedef struct packed {
		logic [39:0] addr;
		ctrl_s       ctrl;
		logic        crc_ok;
	} rx_hdr_s;
	typedef struct packed {
		logic     rst_a, rst_b;
		logic     st_a, st_b, st_c;
		frame_e   ph;
		logic [5:0] cnt;
		logic     done_tgl;
		logic [7:0] byte_q;
		logic     valid, take;
		logic     det_tgl, end_tgl;
		rx_hdr_s  hdr;
	} link_s;
	typedef struct packed {
		logic     ce_a, ce_b, rf_a, rf_b;
		logic     dn_a, dn_b, dn_c;
		logic     dt_a, dt_b, dt_c;
		logic     en_a, en_b, en_c;
		mode_e    mode;
		logic [9:0] ce_cnt;
		logic     ce_ok;
		logic [17:0] tmr;
		logic [17:0] cs_cnt;
		logic     cs_flag;
		logic [3:0] retries;
		logic [5:0] pipe_en;
		logic     locked;
		logic [2:0] lock_pipe;
		logic     start_tgl;
		tx_desc_s desc;
		logic     pop, store, discard, fail;
		logic [2:0] rx_pipe;
		logic [11:0] freq;
	} core_s;
endpackage

/* hdl/air_link.sv */
// link-clock side: byte framer for outgoing packets and capture of
// receive headers; talks to the core only through toggles and held words
`timescale 1ns/1ps
`include "radio_cfg.svh"
module air_link
	import radio_pkg::*;
(
	input  wire logic     link_clk_i,
	input  wire logic     sys_rst_i,
	input  wire logic     start_tgl_i,
	input  wire tx_desc_s desc_i,
	input  wire logic [15:0] air_crc_i,
	input  wire logic [7:0]  payload_byte_i,
	input  wire rx_hdr_s  rx_hdr_i,
	input  wire logic     rx_addr_det_i,
	input  wire logic     rx_end_i,
	output logic          done_tgl_o,
	output logic [7:0]    air_byte_o,
	output logic          air_valid_o,
	output logic          payload_take_o,
	output logic          det_tgl_o,
	output logic          end_tgl_o,
	output rx_hdr_s       hdr_o
);
	link_s q, n;
	logic [5:0] top_bit;
	logic [8:0] ctl;

	always_comb begin
		n = q;
		n.rst_a = sys_rst_i;
		n.rst_b = q.rst_a;
		n.st_a = start_tgl_i;
		n.st_b = q.st_a;
		n.st_c = q.st_b;
		n.valid = 1'b0;
		n.take = 1'b0;
		ctl = desc_i.ctrl;
		top_bit = (desc_i.aw == `AW_3) ? `TOP_BIT_3 :
			(desc_i.aw == `AW_4) ? `TOP_BIT_4 : `TOP_BIT_5;
		// address held by the demodulator at detection, control at end
		if (rx_addr_det_i) begin
			n.det_tgl = ~q.det_tgl;
			n.hdr.addr = rx_hdr_i.addr;
		end
		if (rx_end_i) begin
			n.end_tgl = ~q.end_tgl;
			n.hdr.ctrl = rx_hdr_i.ctrl;
			n.hdr.crc_ok = rx_hdr_i.crc_ok;
		end
		unique case (q.ph)
			F_IDLE: begin
				if (q.st_b ^ q.st_c) begin
					n.ph = F_PRE;
					n.cnt = {3'h0, top_bit[5:3]};
				end
			end
			F_PRE: begin
				n.byte_q = desc_i.addr[top_bit] ? `PRE_ONE : `PRE_ZERO;
				n.valid = 1'b1;
				n.ph = F_ADDR;
			end
			F_ADDR: begin
				n.byte_q = desc_i.addr[{q.cnt[2:0], 3'h0} +: 8];
				n.valid = 1'b1;
				n.cnt = q.cnt - 6'h01;
				if (q.cnt == 6'h00) begin
					n.ph = F_CTL_HI;
				end
			end
			F_CTL_HI: begin
				n.byte_q = {7'h00, ctl[8]};
				n.valid = 1'b1;
				n.ph = F_CTL_LO;
			end
			F_CTL_LO: begin
				n.byte_q = ctl[7:0];
				n.valid = 1'b1;
				n.cnt = (desc_i.ctrl.len == 6'h00) ? 6'h01 : desc_i.ctrl.len;
				n.ph = (desc_i.ctrl.len == 6'h00) ? F_CRC : F_PAY;
			end
			F_PAY: begin
				n.byte_q = payload_byte_i;
				n.valid = 1'b1;
				n.cnt = (q.cnt == 6'h01) ? 6'h01 : q.cnt - 6'h01;
				if (q.cnt == 6'h01) begin
					n.ph = F_CRC;
				end
			end
			F_CRC: begin
				n.byte_q = q.cnt[0] ? air_crc_i[15:8] : air_crc_i[7:0];
				n.valid = 1'b1;
				n.cnt = q.cnt - 6'h01;
				if (q.cnt == 6'h00) begin
					n.ph = F_IDLE;
					n.done_tgl = ~q.done_tgl;
				end
			end
			default: n.ph = F_IDLE;
		endcase
		// take leads its byte by a cycle, so the fifo has the next byte
		// waiting by the edge that samples it; no byte goes out twice
		n.take = (n.ph == F_PAY);
		if (q.rst_b) begin
			n = '0;
			n.rst_a = sys_rst_i;
			n.rst_b = q.rst_a;
		end
	end

	always_ff @(posedge link_clk_i) begin
		q <= n;
	end

	assign done_tgl_o = q.done_tgl;
	assign air_byte_o = q.byte_q;
	assign air_valid_o = q.valid;
	assign payload_take_o = q.take;
	assign det_tgl_o = q.det_tgl;
	assign end_tgl_o = q.end_tgl;
	assign hdr_o = q.hdr;
endmodule

/* hdl/radio_mode_ctrl.sv */
// radio mode controller: power down, two standby modes, transmit and
// receive, retries, carrier sense and pipe address matching.
// assumes host config ports and fifo flags are on CLOCK_I; chip enable
// and rf presence are pins; air side runs on LINK_CLK_I.
`timescale 1ns/1ps
`include "radio_cfg.svh"
module radio_mode_ctrl
	import radio_pkg::*;
#(
	parameter int unsigned TX_MAX_CYC     = `TX_MAX_NS / `CLK_PERIOD_NS,
	parameter int unsigned CS_CYC         =
		(`CS_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
	parameter int unsigned ACK_WAIT_CYC   = `ACK_WAIT_NS / `CLK_PERIOD_NS,
	parameter int unsigned RETRY_STEP_CYC = `RETRY_STEP_NS / `CLK_PERIOD_NS
)(
	input  wire logic        CLOCK_I,
	input  wire logic        SYS_RST_I,
	input  wire logic        LINK_CLK_I,
	input  wire logic        RADIO_POWER_ON_BIT_I,
	input  wire logic        PRIMARY_RECEIVER_SELECT_I,
	input  wire logic        AUTO_ACKNOWLEDGE_ENABLE_I,
	input  wire logic [3:0]  RETRY_LIMIT_I,
	input  wire logic [3:0]  RETRY_WAIT_TIME_I,
	input  wire logic [1:0]  ADDRESS_WIDTH_SETTING_I,
	input  wire logic [6:0]  CHANNEL_SELECT_REGISTER_I,
	input  wire logic        PIPE_ENABLE_WR_I,
	input  wire logic [5:0]  PIPE_ENABLE_BITS_I,
	input  wire logic [39:0] PIPE_ZERO_ADDRESS_I,
	input  wire logic [31:0] PIPE_SHARED_ADDR_I,
	input  wire logic [39:0] PIPE_LOW_BYTES_I,
	input  wire logic        CHIP_ENABLE_I,
	input  wire logic        RF_PRESENT_I,
	input  wire logic        TX_FIFO_EMPTY_I,
	input  wire ctrl_s       TX_CTRL_I,
	input  wire logic        RX_FIFO_FULL_I,
	input  wire logic [15:0] AIR_CRC_I,
	input  wire logic [7:0]  PAYLOAD_BYTE_I,
	input  wire rx_hdr_s     RX_HDR_I,
	input  wire logic        RX_ADDR_DET_I,
	input  wire logic        RX_END_I,
	output mode_e            MODE_O,
	output logic             CARRIER_SENSE_FLAG_O,
	output logic [11:0]      CARRIER_FREQ_MHZ_O,
	output logic [5:0]       PIPE_ENABLE_BITS_O,
	output logic [3:0]       RETRY_COUNTER_O,
	output logic             TX_POP_O,
	output logic             RX_STORE_O,
	output logic             RX_DISCARD_O,
	output logic [2:0]       RX_PIPE_O,
	output logic             RETRY_FAIL_O,
	output logic [7:0]       AIR_BYTE_O,
	output logic             AIR_VALID_O,
	output logic             PAYLOAD_TAKE_O
);
	core_s      q, n;
	logic       done_tgl, det_tgl, end_tgl;
	rx_hdr_s    hdr;
	logic [39:0] pipe_addr [`NUM_PIPES];
	logic [`NUM_PIPES-1:0] hit;
	logic [39:0] mask;
	logic       done_ev, det_ev, end_ev;
	logic       any_hit;
	logic [2:0] hit_idx;
	logic       go_tx, go_ack;
	logic       want_ack;

	air_link u_link (
		.link_clk_i     (LINK_CLK_I),
		.sys_rst_i      (SYS_RST_I),
		.start_tgl_i    (q.start_tgl),
		.desc_i         (q.desc),
		.air_crc_i      (AIR_CRC_I),
		.payload_byte_i (PAYLOAD_BYTE_I),
		.rx_hdr_i       (RX_HDR_I),
		.rx_addr_det_i  (RX_ADDR_DET_I),
		.rx_end_i       (RX_END_I),
		.done_tgl_o     (done_tgl),
		.air_byte_o     (AIR_BYTE_O),
		.air_valid_o    (AIR_VALID_O),
		.payload_take_o (PAYLOAD_TAKE_O),
		.det_tgl_o      (det_tgl),
		.end_tgl_o      (end_tgl),
		.hdr_o          (hdr)
	);

	assign mask = (ADDRESS_WIDTH_SETTING_I == `AW_3) ? `MASK_3 :
		(ADDRESS_WIDTH_SETTING_I == `AW_4) ? `MASK_4 : `MASK_5;

	genvar gi;
	generate
		for (gi = 0; gi < `NUM_PIPES; gi++) begin : g_pipe
			if (gi == 0) begin : g_full
				assign pipe_addr[gi] = PIPE_ZERO_ADDRESS_I;
			end else begin : g_shared
				assign pipe_addr[gi] = {PIPE_SHARED_ADDR_I,
					PIPE_LOW_BYTES_I[8*(gi-1) +: 8]};
			end
			assign hit[gi] = q.pipe_en[gi] &&
				(((hdr.addr ^ pipe_addr[gi]) & mask) == 40'h00_0000_0000);
		end
	endgenerate

	// header words are held by the link side until its next event, so
	// they are stable whenever a synchronised toggle edge is seen here
	assign done_ev = q.dn_b ^ q.dn_c;
	assign det_ev = q.dt_b ^ q.dt_c;
	assign end_ev = q.en_b ^ q.en_c;
	assign want_ack = AUTO_ACKNOWLEDGE_ENABLE_I && !hdr.ctrl.no_ack;

	always_comb begin
		n = q;
		any_hit = 1'b0;
		hit_idx = 3'h0;
		go_tx = 1'b0;
		go_ack = 1'b0;
		for (int i = `NUM_PIPES - 1; i >= 0; i--) begin
			if (hit[i]) begin
				any_hit = 1'b1;
				hit_idx = 3'(i);
			end
		end
		n.ce_a = CHIP_ENABLE_I;
		n.ce_b = q.ce_a;
		n.rf_a = RF_PRESENT_I;
		n.rf_b = q.rf_a;
		n.dn_a = done_tgl;
		n.dn_b = q.dn_a;
		n.dn_c = q.dn_b;
		n.dt_a = det_tgl;
		n.dt_b = q.dt_a;
		n.dt_c = q.dt_b;
		n.en_a = end_tgl;
		n.en_b = q.en_a;
		n.en_c = q.en_b;
		n.pop = 1'b0;
		n.store = 1'b0;
		n.discard = 1'b0;
		n.fail = 1'b0;
		n.tmr = (q.tmr == '0) ? q.tmr : q.tmr - 18'h0_0001;
		n.freq = `FREQ_BASE_MHZ + {5'h00, CHANNEL_SELECT_REGISTER_I};
		if (PIPE_ENABLE_WR_I) begin
			n.pipe_en = PIPE_ENABLE_BITS_I;
		end
		if (q.ce_b) begin
			if (q.ce_cnt != 10'(`CE_MIN_CYC)) begin
				n.ce_cnt = q.ce_cnt + 10'h001;
			end else begin
				n.ce_ok = 1'b1;
			end
		end else begin
			n.ce_cnt = 10'h000;
		end
		if (q.mode == M_RX && q.rf_b) begin
			if (q.cs_cnt == 18'(CS_CYC - 1)) begin
				n.cs_flag = 1'b1;
			end else begin
				n.cs_cnt = q.cs_cnt + 18'h0_0001;
			end
		end else begin
			n.cs_cnt = 18'h0_0000;
			n.cs_flag = 1'b0;
		end

		unique case (q.mode)
			M_OFF: begin
				n.mode = M_STBY1;
			end
			M_STBY1: begin
				if (q.ce_b && PRIMARY_RECEIVER_SELECT_I) begin
					n.mode = M_RX;
					n.locked = 1'b0;
				end else if (!PRIMARY_RECEIVER_SELECT_I && q.ce_ok &&
						!TX_FIFO_EMPTY_I) begin
					go_tx = 1'b1;
				end
			end
			M_STBY2: begin
				if (!q.ce_b) begin
					n.mode = M_STBY1;
				end else if (!TX_FIFO_EMPTY_I && !q.pop) begin
					go_tx = 1'b1;
				end
			end
			M_TX: begin
				if (done_ev || q.tmr == '0) begin
					if (AUTO_ACKNOWLEDGE_ENABLE_I && !q.desc.ctrl.no_ack) begin
						n.mode = M_ACK_WAIT;
						n.tmr = `TMR_W'(ACK_WAIT_CYC - 1);
					end else begin
						n.pop = 1'b1;
						n.retries = 4'h0;
						n.mode = q.ce_b ? M_STBY2 : M_STBY1;
					end
				end
			end
			M_ACK_WAIT: begin
				if (end_ev && hdr.crc_ok && hit[0]) begin
					n.pop = 1'b1;
					n.retries = 4'h0;
					n.mode = q.ce_b ? M_STBY2 : M_STBY1;
				end else if (q.tmr == '0) begin
					if (q.retries < RETRY_LIMIT_I) begin
						n.retries = q.retries + 4'h1;
						n.mode = M_RETRY;
						n.tmr = `TMR_W'((RETRY_WAIT_TIME_I + 1) * RETRY_STEP_CYC - 1);
					end else begin
						// payload stays queued so the host may reuse it
						n.fail = 1'b1;
						n.mode = M_STBY1;
					end
				end
			end
			M_RETRY: begin
				if (q.tmr == '0) begin
					go_tx = 1'b1;
				end
			end
			M_RX: begin
				if (det_ev && !q.locked && any_hit) begin
					n.locked = 1'b1;
					n.lock_pipe = hit_idx;
				end
				if (end_ev && q.locked) begin
					n.locked = 1'b0;
					n.rx_pipe = q.lock_pipe;
					if (hdr.crc_ok && !RX_FIFO_FULL_I) begin
						n.store = 1'b1;
					end else begin
						n.discard = 1'b1;
					end
					if (hdr.crc_ok && want_ack) begin
						go_ack = 1'b1;
					end
				end
				if (!q.ce_b) begin
					n.mode = M_STBY1;
					n.locked = 1'b0;
					go_ack = 1'b0;
				end
			end
			M_ACK_TX: begin
				if (done_ev || q.tmr == '0) begin
					n.mode = q.ce_b ? M_RX : M_STBY1;
				end
			end
		endcase

		if (go_tx) begin
			// transmit address equals pipe zero so the ack can match it
			n.mode = M_TX;
			n.tmr = `TMR_W'(TX_MAX_CYC - 1);
			n.start_tgl = ~q.start_tgl;
			n.ce_ok = 1'b0;
			if (q.mode != M_RETRY) begin
				n.retries = 4'h0;
			end
			n.desc.addr = PIPE_ZERO_ADDRESS_I;
			n.desc.aw = ADDRESS_WIDTH_SETTING_I;
			n.desc.ctrl = TX_CTRL_I;
		end
		if (go_ack) begin
			n.mode = M_ACK_TX;
			n.tmr = `TMR_W'(TX_MAX_CYC - 1);
			n.start_tgl = ~q.start_tgl;
			n.desc.addr = pipe_addr[q.lock_pipe];
			n.desc.aw = ADDRESS_WIDTH_SETTING_I;
			n.desc.ctrl.len = 6'h00;
			n.desc.ctrl.tag = hdr.ctrl.tag;
			n.desc.ctrl.no_ack = 1'b1;
		end

		if (!RADIO_POWER_ON_BIT_I) begin
			n.mode = M_OFF;
			n.ce_ok = 1'b0;
			n.locked = 1'b0;
			n.start_tgl = q.start_tgl;
			n.tmr = 18'h0_0000;
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			q <= '0;
			q.pipe_en <= `PIPE_EN_RST;
			q.freq <= `FREQ_BASE_MHZ;
		end else begin
			q <= n;
		end
	end

	assign MODE_O = q.mode;
	assign CARRIER_SENSE_FLAG_O = q.cs_flag;
	assign CARRIER_FREQ_MHZ_O = q.freq;
	assign PIPE_ENABLE_BITS_O = q.pipe_en;
	assign RETRY_COUNTER_O = q.retries;
	assign TX_POP_O = q.pop;
	assign RX_STORE_O = q.store;
	assign RX_DISCARD_O = q.discard;
	assign RX_PIPE_O = q.rx_pipe;
	assign RETRY_FAIL_O = q.fail;
endmodule

/* dv/radio_mode_ctrl_monitor.sv */
// concurrent checks on the radio mode controller's top ports
// assumes a bind from the design top, which hands on the short counts
`timescale 1ns/1ps
module radio_mode_ctrl_monitor
	import radio_pkg::*;
#(
	parameter int unsigned TX_MAX_CYC     = 200,
	parameter int unsigned CS_CYC         = 16,
	parameter int unsigned RETRY_STEP_CYC = 20
)(
	input wire logic        CLOCK_I,
	input wire logic        SYS_RST_I,
	input wire logic        RADIO_POWER_ON_BIT_I,
	input wire logic        AUTO_ACKNOWLEDGE_ENABLE_I,
	input wire logic [3:0]  RETRY_LIMIT_I,
	input wire logic [3:0]  RETRY_WAIT_TIME_I,
	input wire logic [6:0]  CHANNEL_SELECT_REGISTER_I,
	input wire logic        PIPE_ENABLE_WR_I,
	input wire logic [5:0]  PIPE_ENABLE_BITS_I,
	input wire logic        CHIP_ENABLE_I,
	input wire logic        RF_PRESENT_I,
	input wire logic        TX_FIFO_EMPTY_I,
	input wire ctrl_s       TX_CTRL_I,
	input wire logic        RX_FIFO_FULL_I,
	input wire mode_e       MODE_O,
	input wire logic        CARRIER_SENSE_FLAG_O,
	input wire logic [11:0] CARRIER_FREQ_MHZ_O,
	input wire logic [5:0]  PIPE_ENABLE_BITS_O,
	input wire logic [3:0]  RETRY_COUNTER_O,
	input wire logic        TX_POP_O,
	input wire logic        RX_STORE_O,
	input wire logic        RX_DISCARD_O
);
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (SYS_RST_I);
	logic [9:0] rf_run, tx_run, rt_run;
	// run lengths saturate so a long stretch of their condition cannot wrap to zero
	always_ff @(posedge CLOCK_I) begin
		rf_run <= (SYS_RST_I || !RF_PRESENT_I) ? '0 : rf_run + {9'h000, ~&rf_run};
		tx_run <= (SYS_RST_I || MODE_O != M_TX) ? '0 : tx_run + {9'h000, ~&tx_run};
		rt_run <= (SYS_RST_I || MODE_O != M_RETRY) ? '0 : rt_run + {9'h000, ~&rt_run};
	end
	sequence s_retry_in;
		$rose(MODE_O == M_RETRY);
	endsequence
	sequence s_retry_out;
		$fell(MODE_O == M_RETRY);
	endsequence
	a_power_off_sleep: assert property (!RADIO_POWER_ON_BIT_I |=> MODE_O == M_OFF)
		else $error("mode not off with power bit low");
	a_ce_low_standby: assert property ((!CHIP_ENABLE_I)[*3] |=>
		!(MODE_O inside {M_RX, M_STBY2}))
		else $error("chip enable low but still active");
	a_stby2_resume: assert property (MODE_O == M_STBY2 && !TX_FIFO_EMPTY_I &&
		!TX_POP_O && CHIP_ENABLE_I |-> ##[1:2] MODE_O == M_TX)
		else $error("queued packet not resumed");
	a_tx_time_cap: assert property (tx_run <= TX_MAX_CYC)
		else $error("transmit held too long");
	a_retry_below_limit: assert property (s_retry_in |-> $past(RETRY_COUNTER_O) < RETRY_LIMIT_I)
		else $error("retry begun at the limit");
	a_retry_wait_span: assert property (s_retry_out |->
		rt_run >= (RETRY_WAIT_TIME_I + 1) * RETRY_STEP_CYC &&
		rt_run <= (RETRY_WAIT_TIME_I + 1) * RETRY_STEP_CYC + 1)
		else $error("retry wait of wrong length");
	a_ack_wait_gate: assert property ($rose(MODE_O == M_ACK_WAIT) |->
		AUTO_ACKNOWLEDGE_ENABLE_I && !TX_CTRL_I.no_ack)
		else $error("awaiting ack that was not requested");
	a_store_not_full: assert property (RX_STORE_O |-> !$past(RX_FIFO_FULL_I) && !RX_DISCARD_O)
		else $error("store while fifo full");
	a_carrier_filter: assert property ($rose(CARRIER_SENSE_FLAG_O) |->
		rf_run >= CS_CYC && MODE_O == M_RX)
		else $error("carrier flag set too early");
	a_pipe_en_write: assert property (PIPE_ENABLE_WR_I |=>
		PIPE_ENABLE_BITS_O == $past(PIPE_ENABLE_BITS_I))
		else $error("pipe enable write lost");
	a_freq_channel: assert property (!SYS_RST_I |=> CARRIER_FREQ_MHZ_O ==
		12'h0960 + {5'h00, $past(CHANNEL_SELECT_REGISTER_I)})
		else $error("carrier frequency wrong");
endmodule
bind radio_mode_ctrl radio_mode_ctrl_monitor #(
	.TX_MAX_CYC(TX_MAX_CYC), .CS_CYC(CS_CYC), .RETRY_STEP_CYC(RETRY_STEP_CYC)
) u_radio_mode_ctrl_monitor (
	.CLOCK_I(CLOCK_I), .SYS_RST_I(SYS_RST_I), .RADIO_POWER_ON_BIT_I(RADIO_POWER_ON_BIT_I),
	.AUTO_ACKNOWLEDGE_ENABLE_I(AUTO_ACKNOWLEDGE_ENABLE_I), .RETRY_LIMIT_I(RETRY_LIMIT_I),
	.RETRY_WAIT_TIME_I(RETRY_WAIT_TIME_I), .CHANNEL_SELECT_REGISTER_I(CHANNEL_SELECT_REGISTER_I),
	.PIPE_ENABLE_WR_I(PIPE_ENABLE_WR_I), .PIPE_ENABLE_BITS_I(PIPE_ENABLE_BITS_I),
	.CHIP_ENABLE_I(CHIP_ENABLE_I), .RF_PRESENT_I(RF_PRESENT_I), .TX_CTRL_I(TX_CTRL_I),
	.TX_FIFO_EMPTY_I(TX_FIFO_EMPTY_I), .RX_FIFO_FULL_I(RX_FIFO_FULL_I), .MODE_O(MODE_O),
	.CARRIER_SENSE_FLAG_O(CARRIER_SENSE_FLAG_O), .CARRIER_FREQ_MHZ_O(CARRIER_FREQ_MHZ_O),
	.PIPE_ENABLE_BITS_O(PIPE_ENABLE_BITS_O), .RETRY_COUNTER_O(RETRY_COUNTER_O),
	.TX_POP_O(TX_POP_O), .RX_STORE_O(RX_STORE_O), .RX_DISCARD_O(RX_DISCARD_O)
);

/* dv/peer_radio.sv */
// peer radio on the link clock: plays received packets into the header
// port, feeds payload bytes and records every byte sent on air
`timescale 1ns/1ps
module peer_radio
	import radio_pkg::*;
(
	input  wire logic       link_clk_i,
	input  wire logic       rst_i,
	input  wire logic [7:0] air_byte_i,
	input  wire logic       air_valid_i,
	input  wire logic       take_i,
	output logic [7:0]      payload_o,
	output logic [15:0]     crc_o,
	output rx_hdr_s         hdr_o,
	output logic            det_o,
	output logic            end_o
);
	logic [7:0] seen[$];
	assign crc_o = 16'hBEEF;
	initial {hdr_o, det_o, end_o} = '0;
	always @(posedge link_clk_i) begin
		if (air_valid_i)
			seen.push_back(air_byte_i);
		if (rst_i)
			payload_o <= 8'hC0;
		else if (take_i)
			payload_o <= payload_o + 8'h01;
	end
	// fields are valid only with their pulse; otherwise they show the
	// inverse so a design reading them late sees garbage, not stale data
	task automatic play(input logic [39:0] a, input ctrl_s c, input logic ok);
		@(posedge link_clk_i);
		hdr_o <= {a, ~c, ~ok};
		det_o <= 1'b1;
		@(posedge link_clk_i);
		det_o <= 1'b0;
		hdr_o <= {~a, ~c, ~ok};
		repeat (4) @(posedge link_clk_i);
		hdr_o <= {~a, c, ok};
		end_o <= 1'b1;
		@(posedge link_clk_i);
		end_o <= 1'b0;
		hdr_o <= {~a, ~c, ~ok};
	endtask
endmodule

/* dv/radio_mode_ctrl_bench.sv */
// self-checking bench for the radio mode controller and its air framer
// assumes short counts below; peer radio model sits on the link side
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
	$display("[FAIL] %0t got %0h want %0h", $time, a, b); end end
`define WT(c) for (int w = 0; w < 4000 && !(c); w++) @(negedge clk)
module radio_mode_ctrl_bench
	import radio_pkg::*;
;
	logic        clk = 0, lclk = 0, rst, pwr, primary_receiver_role, aa, pwr_wr, ce, rf, empty, full;
	logic        cs, pop, store, disc, fail, avalid, take, det, fin, s_hit, d_hit;
	logic [3:0]  lim, rwt, rcnt;
	logic [1:0]  aw;
	logic [6:0]  ch;
	logic [5:0]  pen, pen_o;
	logic [39:0] p0, lows;
	logic [31:0] shr;
	logic [11:0] freq;
	logic [2:0]  rpipe;
	logic [7:0]  abyte, pbyte;
	logic [15:0] crc;
	ctrl_s       ctl;
	rx_hdr_s     hdr;
	mode_e       mode;
	int          n_mismatch = 0, n_compared = 0, cyc = 0;
	// peer fifo bytes count up from the peer's reset value
	logic [7:0]  pnext = 8'hC0;
	always #12.5 clk = ~clk;
	// offset start keeps link edges off the core edges
	always begin #7; forever #62.5 lclk = ~lclk; end
	radio_mode_ctrl #(.TX_MAX_CYC(400), .CS_CYC(16), .ACK_WAIT_CYC(100), .RETRY_STEP_CYC(20))
	u_radio_mode_ctrl (
		.CLOCK_I(clk), .SYS_RST_I(rst), .LINK_CLK_I(lclk), .RADIO_POWER_ON_BIT_I(pwr),
		.PRIMARY_RECEIVER_SELECT_I(primary_receiver_role), .AUTO_ACKNOWLEDGE_ENABLE_I(aa), .RETRY_LIMIT_I(lim),
		.RETRY_WAIT_TIME_I(rwt), .ADDRESS_WIDTH_SETTING_I(aw), .CHANNEL_SELECT_REGISTER_I(ch),
		.PIPE_ENABLE_WR_I(pwr_wr), .PIPE_ENABLE_BITS_I(pen), .PIPE_ZERO_ADDRESS_I(p0),
		.PIPE_SHARED_ADDR_I(shr), .PIPE_LOW_BYTES_I(lows), .CHIP_ENABLE_I(ce),
		.RF_PRESENT_I(rf), .TX_FIFO_EMPTY_I(empty), .TX_CTRL_I(ctl), .RX_FIFO_FULL_I(full),
		.AIR_CRC_I(crc), .PAYLOAD_BYTE_I(pbyte), .RX_HDR_I(hdr), .RX_ADDR_DET_I(det),
		.RX_END_I(fin), .MODE_O(mode), .CARRIER_SENSE_FLAG_O(cs), .CARRIER_FREQ_MHZ_O(freq),
		.PIPE_ENABLE_BITS_O(pen_o), .RETRY_COUNTER_O(rcnt), .TX_POP_O(pop),
		.RX_STORE_O(store), .RX_DISCARD_O(disc), .RX_PIPE_O(rpipe), .RETRY_FAIL_O(fail),
		.AIR_BYTE_O(abyte), .AIR_VALID_O(avalid), .PAYLOAD_TAKE_O(take)
	);
	peer_radio u_peer_radio (
		.link_clk_i(lclk), .rst_i(rst), .air_byte_i(abyte), .air_valid_i(avalid),
		.take_i(take), .payload_o(pbyte), .crc_o(crc), .hdr_o(hdr), .det_o(det), .end_o(fin)
	);
	task automatic frame_chk(input int nb, input logic [39:0] a, input ctrl_s c);
		logic [7:0] e[$];
		logic [7:0] b;
		int         n;
		// the last byte reaches the peer a link edge after the done toggle
		repeat (2) @(posedge lclk);
		e.push_back(a[8*nb-1] ? 8'hAA : 8'h55);
		for (int i = nb - 1; i >= 0; i--) e.push_back(a[8*i+:8]);
		e.push_back({7'h00, c.len[5]});
		e.push_back({c.len[4:0], c.tag, c.no_ack});
		n = e.size() + int'(c.len) + 2;
		`CHK(u_peer_radio.seen.size() >= n, 1'b1) // whole frame sent
		for (int i = 0; i < n; i++) begin
			b = u_peer_radio.seen.pop_front();
			if (i < e.size()) `CHK(b, e[i]) // header bytes
			else if (i >= n - 2) `CHK(b, i == n - 2 ? 8'hBE : 8'hEF) // check bytes last
			else begin
				`CHK(b, pnext) // payload in fifo order
				pnext++;
			end
		end
	endtask
	task automatic rx_case(input logic [39:0] a, input ctrl_s c, input logic ok, f, es, ed,
		input logic [2:0] ep);
		@(posedge clk) full <= f;
		s_hit = 0;
		d_hit = 0;
		fork
			u_peer_radio.play(a, c, ok);
			repeat (80) begin
				@(negedge clk);
				s_hit |= store;
				d_hit |= disc;
			end
		join
		`CHK(s_hit, es) // store decision
		`CHK(d_hit, ed) // discard decision
		if (es | ed) `CHK(rpipe, ep) // arrival pipe
	endtask
	task summarize;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			$display("[FAIL] %0t watchdog ran out", $time);
			summarize();
		end
	end
	initial begin
		{rst, pwr, primary_receiver_role, aa, pwr_wr, ce, rf, full, empty} = 9'h181;
		{lim, rwt, aw, ch, pen} = {4'h1, 4'h0, 2'h0, 7'h05, 6'h00};
		{p0, shr, lows} = {40'h80_1122_3344, 32'h5566_7788, 40'h55_4433_2211};
		ctl = '{6'h02, 2'h1, 1'b0};
		// held past four link edges so the link side leaves reset too
		repeat (24) @(posedge clk);
		rst <= 0;
		repeat (2) @(negedge clk);
		`CHK(pen_o, 6'h03) // two pipes after reset
		`CHK(freq, 12'h0965) // base plus channel
		`CHK(mode, M_STBY1) // powered with ce low
		@(posedge clk) pwr <= 0; // power bit cleared first
		repeat (3) @(negedge clk);
		`CHK(mode, M_OFF) // sleep when power bit low
		@(posedge clk) {pwr_wr, pen} <= {1'b1, 6'h05};
		@(posedge clk) pwr_wr <= 0;
		@(negedge clk) `CHK(pen_o, 6'h05) // config live while off
		$display("test power done");
		// power on, payload queued, ce held well past the minimum
		@(posedge clk) {pwr, empty, ce} <= 3'h5;
		`WT(pop);
		@(posedge clk) empty <= 1;
		frame_chk(5, p0, ctl); // five byte address
		repeat (4) @(negedge clk);
		`CHK(mode, M_STBY2) // parks when fifo empty
		@(posedge clk) {aw, p0, ctl, empty} <= {2'h1, 40'h99_002A_BBCC, 9'h005, 1'b0};
		`WT(mode == M_TX);
		`CHK(mode, M_TX) // resumes on new packet
		`WT(pop);
		@(posedge clk) {empty, ce} <= 2'h2;
		frame_chk(3, p0, ctl); // three byte address
		repeat (4) @(negedge clk);
		`CHK(mode, M_STBY1) // ce low ends standby two
		$display("test transmit done");
		@(posedge clk) {aa, ctl, empty, ce} <= {1'b1, 9'h006, 1'b0, 1'b1};
		`WT(mode == M_TX);
		@(posedge clk) ce <= 0;
		`WT(fail);
		`CHK(fail, 1'b1) // give-up pulse seen
		`CHK(pop, 1'b0) // no pop when retries run out
		`CHK(rcnt, 4'h1) // exactly the limit of retries
		@(posedge clk) empty <= 1;
		frame_chk(3, p0, ctl); // first attempt
		frame_chk(3, p0, ctl); // one retransmission
		repeat (4) @(negedge clk);
		`CHK(mode, M_STBY1) // gives up to standby
		@(posedge clk) {empty, ce} <= 2'h1;
		`WT(mode == M_TX);
		`CHK(rcnt, 4'h0) // new packet clears count
		@(posedge clk) ce <= 0;
		`WT(mode == M_ACK_WAIT);
		u_peer_radio.play(p0, '{6'h00, 2'h3, 1'b1}, 1'b1);
		`WT(pop);
		`CHK(pop, 1'b1) // ack accepted
		`CHK(rcnt, 4'h0) // no retry needed
		@(posedge clk) {empty, aa} <= 2'h2;
		repeat (60) @(negedge clk);
		u_peer_radio.seen.delete();
		$display("test retry done");
		@(posedge clk) {primary_receiver_role, ce, rf} <= 3'h7;
		`WT(mode == M_RX);
		`CHK(mode, M_RX) // enters receive
		repeat (10) @(negedge clk);
		`CHK(cs, 1'b0) // flag waits for filter
		repeat (20) @(negedge clk);
		`CHK(cs, 1'b1) // flag after filter time
		@(posedge clk) rf <= 0;
		rx_case({shr, lows[15:8]}, '{6'h04, 2'h0, 1'b0}, 1, 0, 1, 0, 3'h2); // pipe two
		rx_case({shr, lows[15:8]}, '{6'h04, 2'h1, 1'b0}, 0, 0, 0, 1, 3'h2); // bad check
		rx_case(p0, '{6'h01, 2'h2, 1'b0}, 1, 1, 0, 1, 3'h0); // fifo full
		rx_case({shr, lows[7:0]}, '{6'h01, 2'h3, 1'b0}, 1, 0, 0, 0, 3'h0); // pipe one off
		`CHK(u_peer_radio.seen.size() == 0, 1'b1) // no ack when disabled
		@(posedge clk) aa <= 1;
		rx_case({shr, lows[15:8]}, '{6'h02, 2'h2, 1'b0}, 1, 0, 1, 0, 3'h2); // acked packet
		`WT(mode == M_RX);
		frame_chk(3, {shr, lows[15:8]}, '{6'h00, 2'h2, 1'b1}); // ack to arrival pipe
		$display("test receive done");
		summarize();
	end
endmodule
